// >>> logic/dccr_map.svh
// register map, field positions, reset values and divider constants of the config bank
`ifndef DCCR_MAP_SVH
`define DCCR_MAP_SVH
// ****************************************
// register addresses
// ****************************************
`define DCCR_A_MODE 6'h01
`define DCCR_A_BLANK 6'h02
`define DCCR_A_CHANNEL_CLOCK_DIVIDER 6'h03
`define DCCR_A_SLOPE 6'h04
`define DCCR_A_SPREAD 6'h05
`define DCCR_A_SOFT 6'h06
`define DCCR_A_IADJ1 6'h07
`define DCCR_A_IADJ2 6'h08
`define DCCR_A_DIMDIV 6'h09
`define DCCR_A_W1L 6'h0A
`define DCCR_A_W1H 6'h0B
`define DCCR_A_W2L 6'h0C
`define DCCR_A_W2H 6'h0D
`define DCCR_A_LHCFG 6'h17
`define DCCR_A_LHIADJ1 6'h18
`define DCCR_A_LHIADJ2 6'h19
`define DCCR_A_LHW1L 6'h1A
`define DCCR_A_LHW1H 6'h1B
`define DCCR_A_LHW2L 6'h1C
`define DCCR_A_LHW2H 6'h1D
// ****************************************
// reset values
// ****************************************
`define DCCR_R_ZERO 8'h00
`define DCCR_R_SLOPE 8'h55
`define DCCR_R_SPREAD 8'h05
`define DCCR_R_SOFT 8'h77
`define DCCR_R_DIMDIV 8'h01
`define DCCR_R_LHCFG 8'h3C
// ****************************************
// writable bit masks, reserved bits are zero
// ****************************************
`define DCCR_M_MODE 8'hEF
`define DCCR_M_BLANK 8'hC9
`define DCCR_M_CHANNEL_CLOCK_DIVIDER 8'h0F
`define DCCR_M_SLOPE 8'h77
`define DCCR_M_SPREAD 8'h3F
`define DCCR_M_DIMDIV 8'h07
`define DCCR_M_WH 8'h03
// ****************************************
// field positions
// ****************************************
`define DCCR_B_PHASE 7
`define DCCR_B_INTDIM 6
`define DCCR_B_DUAL 5
`define DCCR_B_LH 4
`define DCCR_B_GAIN 2
`define DCCR_B_CV 0
`define DCCR_B_LEB 6
`define DCCR_B_FILT2 3
`define DCCR_B_FILT1 0
`define DCCR_B_SMAG 4
// ****************************************
// divider constants
// ****************************************
`define DCCR_SW_MIN 4'h2
`define DCCR_SW_MAX 4'h8
`define DCCR_SW_TOP 2'h3
`define DCCR_FM_BASE 13'h1000
`define DCCR_FM_STEP 13'h0200
`define DCCR_FM_FINE 13'h0100
`define DCCR_FM_SPLIT 4'h8
`define DCCR_FM_OFF 4'hE
`define DCCR_SS_DIVS {7'h64, 7'h50, 7'h40, 7'h36, 7'h2E, 7'h26, 7'h20, 7'h1A, \
  7'h14, 7'h10, 7'h0C, 7'h08, 7'h06, 7'h04, 7'h02, 7'h00}
`define DCCR_SS_W 7
`define DCCR_IADJ_OFF 8'h08
`define DCCR_RAMP_TOP 8'hFF
`define DCCR_DIM_HALF 10'h200
`endif

// >>> logic/dccr_pkg.sv
// types shared by the dual channel config bank
`default_nettype none
package dccr_pkg;
  typedef logic [7:0] dccr_byte_t;
  typedef logic [9:0] dccr_width_t;
  typedef logic [12:0] dccr_fmdiv_t;
endpackage
`default_nettype wire

// >>> logic/dccr_config_bank.sv
// dual channel configuration register bank with clock dividers and dimming generator
// Function
// - phase bit 0 shifts internal dimming 180 degrees, 1 keeps it in phase
// - internal-dimming bit 0 uses external dimming pins, 1 internal generator
// - dual-phase bit picks two single channels or one dual-phase pair
// - limp-home pin high sets and holds the limp-home bit
// - only reset or a serial write of zero clears the limp-home bit
// - in limp-home the alternate register set drives the logic
// - limp-home ends only with pin low and bit written zero or cleared by reset
// - gain bit selects low or high error amplifier gain per channel
// - regulation bit selects constant current or constant voltage per channel
// - blanking bit selects short or long leading edge blanking
// - channel clock is main clock over 2, 4, 8, code three also 8
// - three-bit slope code sets ramp peak in 50 mV steps
// - spread magnitude code zero disables, others select 3.75, 7.5, 15 percent
// - spread rate code sets modulation divider, codes 14 and 15 disable
// - soft-start code sets ramp counter clock divider, zero disables soft-start
// - dual-phase uses channel one soft-start and current codes for both
// - current code eight or less turns channel off, above drives the DAC
// - dimming clock divides main clock by divider code plus one
// - low width register gives eight low bits of dimming width
// - high width register gives two top bits of dimming width
`timescale 1ns/100ps
`include "dccr_map.svh"
`default_nettype none
module dccr_config_bank (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port from the serial front end
  input wire logic reg_wr_stb,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic limp_home_pin,
  input wire logic [1:0] ext_dimming_in,
  // mode settings
  output logic dimming_phase_select,
  output logic internal_dimming_select,
  output logic dual_phase_select,
  output logic limp_home_active,
  output logic [1:0] error_amp_gain_select,
  output logic [1:0] regulation_mode_select,
  output logic [1:0] blanking_length_select,
  output logic [1:0] current_limit_filter_select,
  output logic [5:0] slope_ramp_code,
  // clocks and modulation
  output logic [1:0] channel_clock_tick,
  output logic [1:0] spread_magnitude,
  output logic spread_tick,
  output logic dimming_clock_tick,
  // per channel drive
  output logic [15:0] current_adjust_code,
  output logic [1:0] channel_on,
  output logic [15:0] soft_start_divider_ramp,
  output logic [1:0] dimming_out
);
  // ****************************************
  // register storage
  // ****************************************
  dccr_pkg::dccr_byte_t mode_ff, blank_ff, channel_clock_divider_ff, slope_ff, spread_ff, soft_ff;
  dccr_pkg::dccr_byte_t iadj1_ff, iadj2_ff, dimdiv_ff, w1l_ff, w1h_ff, w2l_ff, w2h_ff;
  dccr_pkg::dccr_byte_t lhcfg_ff, lhiadj1_ff, lhiadj2_ff, lhw1l_ff, lhw1h_ff;
  dccr_pkg::dccr_byte_t lhw2l_ff, lhw2h_ff;
  logic lh_bit_ff;
  logic nxt_lh_bit;
  logic wr_mode;
  dccr_pkg::dccr_byte_t nxt_rdata;

  assign wr_mode = reg_wr_stb && (reg_addr == `DCCR_A_MODE);

  // register writes, reserved bits masked off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= `DCCR_R_ZERO;
      blank_ff <= `DCCR_R_ZERO;
      channel_clock_divider_ff <= `DCCR_R_ZERO;
      slope_ff <= `DCCR_R_SLOPE;
      spread_ff <= `DCCR_R_SPREAD;
      soft_ff <= `DCCR_R_SOFT;
      iadj1_ff <= `DCCR_R_ZERO;
      iadj2_ff <= `DCCR_R_ZERO;
      dimdiv_ff <= `DCCR_R_DIMDIV;
      w1l_ff <= `DCCR_R_ZERO;
      w1h_ff <= `DCCR_R_ZERO;
      w2l_ff <= `DCCR_R_ZERO;
      w2h_ff <= `DCCR_R_ZERO;
      lhcfg_ff <= `DCCR_R_LHCFG;
      lhiadj1_ff <= `DCCR_R_ZERO;
      lhiadj2_ff <= `DCCR_R_ZERO;
      lhw1l_ff <= `DCCR_R_ZERO;
      lhw1h_ff <= `DCCR_R_ZERO;
      lhw2l_ff <= `DCCR_R_ZERO;
      lhw2h_ff <= `DCCR_R_ZERO;
    end else if (reg_wr_stb) begin
      unique case (reg_addr)
        `DCCR_A_MODE: mode_ff <= reg_wdata & `DCCR_M_MODE;
        `DCCR_A_BLANK: blank_ff <= reg_wdata & `DCCR_M_BLANK;
        `DCCR_A_CHANNEL_CLOCK_DIVIDER: channel_clock_divider_ff <= reg_wdata & `DCCR_M_CHANNEL_CLOCK_DIVIDER;
        `DCCR_A_SLOPE: slope_ff <= reg_wdata & `DCCR_M_SLOPE;
        `DCCR_A_SPREAD: spread_ff <= reg_wdata & `DCCR_M_SPREAD;
        `DCCR_A_SOFT: soft_ff <= reg_wdata;
        `DCCR_A_IADJ1: iadj1_ff <= reg_wdata;
        `DCCR_A_IADJ2: iadj2_ff <= reg_wdata;
        `DCCR_A_DIMDIV: dimdiv_ff <= reg_wdata & `DCCR_M_DIMDIV;
        `DCCR_A_W1L: w1l_ff <= reg_wdata;
        `DCCR_A_W1H: w1h_ff <= reg_wdata & `DCCR_M_WH;
        `DCCR_A_W2L: w2l_ff <= reg_wdata;
        `DCCR_A_W2H: w2h_ff <= reg_wdata & `DCCR_M_WH;
        `DCCR_A_LHCFG: lhcfg_ff <= reg_wdata;
        `DCCR_A_LHIADJ1: lhiadj1_ff <= reg_wdata;
        `DCCR_A_LHIADJ2: lhiadj2_ff <= reg_wdata;
        `DCCR_A_LHW1L: lhw1l_ff <= reg_wdata;
        `DCCR_A_LHW1H: lhw1h_ff <= reg_wdata & `DCCR_M_WH;
        `DCCR_A_LHW2L: lhw2l_ff <= reg_wdata;
        `DCCR_A_LHW2H: lhw2h_ff <= reg_wdata & `DCCR_M_WH;
        default: ;
      endcase
    end
  end

  // ****************************************
  // limp-home latch
  // ****************************************
  // pin set beats a same-cycle write of zero; a written one leaves the bit alone
  assign nxt_lh_bit = limp_home_pin |
    (lh_bit_ff & ~(wr_mode & ~reg_wdata[`DCCR_B_LH]));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lh_bit_ff <= 1'b0;
    end else begin
      lh_bit_ff <= nxt_lh_bit;
    end
  end

  // mode lasts while the pin is high or the bit is still set
  assign limp_home_active = lh_bit_ff | limp_home_pin;

  // ****************************************
  // register read back
  // ****************************************
  always_comb begin
    nxt_rdata = `DCCR_R_ZERO;
    unique case (reg_addr)
      `DCCR_A_MODE: nxt_rdata = mode_ff | ({7'h00, lh_bit_ff} << `DCCR_B_LH);
      `DCCR_A_BLANK: nxt_rdata = blank_ff;
      `DCCR_A_CHANNEL_CLOCK_DIVIDER: nxt_rdata = channel_clock_divider_ff;
      `DCCR_A_SLOPE: nxt_rdata = slope_ff;
      `DCCR_A_SPREAD: nxt_rdata = spread_ff;
      `DCCR_A_SOFT: nxt_rdata = soft_ff;
      `DCCR_A_IADJ1: nxt_rdata = iadj1_ff;
      `DCCR_A_IADJ2: nxt_rdata = iadj2_ff;
      `DCCR_A_DIMDIV: nxt_rdata = dimdiv_ff;
      `DCCR_A_W1L: nxt_rdata = w1l_ff;
      `DCCR_A_W1H: nxt_rdata = w1h_ff;
      `DCCR_A_W2L: nxt_rdata = w2l_ff;
      `DCCR_A_W2H: nxt_rdata = w2h_ff;
      `DCCR_A_LHCFG: nxt_rdata = lhcfg_ff;
      `DCCR_A_LHIADJ1: nxt_rdata = lhiadj1_ff;
      `DCCR_A_LHIADJ2: nxt_rdata = lhiadj2_ff;
      `DCCR_A_LHW1L: nxt_rdata = lhw1l_ff;
      `DCCR_A_LHW1H: nxt_rdata = lhw1h_ff;
      `DCCR_A_LHW2L: nxt_rdata = lhw2l_ff;
      `DCCR_A_LHW2H: nxt_rdata = lhw2h_ff;
      default: nxt_rdata = `DCCR_R_ZERO; // unmapped reads zero
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `DCCR_R_ZERO;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ****************************************
  // effective settings, normal or limp-home set
  // ****************************************
  dccr_pkg::dccr_byte_t eff_iadj_ff [2];
  dccr_pkg::dccr_width_t eff_width_ff [2];
  logic [3:0] eff_soft_ff [2];
  logic dual;

  assign dual = mode_ff[`DCCR_B_DUAL];

  // limp-home swaps in its own set; dual phase copies channel one current and soft-start codes, widths stay per channel
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dimming_phase_select <= 1'b0;
      internal_dimming_select <= 1'b0;
      eff_iadj_ff[0] <= `DCCR_R_ZERO;
      eff_iadj_ff[1] <= `DCCR_R_ZERO;
      eff_width_ff[0] <= '0;
      eff_width_ff[1] <= '0;
      eff_soft_ff[0] <= 4'h0;
      eff_soft_ff[1] <= 4'h0;
    end else if (limp_home_active) begin
      dimming_phase_select <= lhcfg_ff[`DCCR_B_PHASE];
      internal_dimming_select <= lhcfg_ff[`DCCR_B_INTDIM];
      eff_iadj_ff[0] <= lhiadj1_ff;
      eff_iadj_ff[1] <= dual ? lhiadj1_ff : lhiadj2_ff;
      eff_width_ff[0] <= {lhw1h_ff[1:0], lhw1l_ff};
      eff_width_ff[1] <= {lhw2h_ff[1:0], lhw2l_ff};
      eff_soft_ff[0] <= soft_ff[3:0];
      eff_soft_ff[1] <= dual ? soft_ff[3:0] : soft_ff[7:4];
    end else begin
      dimming_phase_select <= mode_ff[`DCCR_B_PHASE];
      internal_dimming_select <= mode_ff[`DCCR_B_INTDIM];
      eff_iadj_ff[0] <= iadj1_ff;
      eff_iadj_ff[1] <= dual ? iadj1_ff : iadj2_ff;
      eff_width_ff[0] <= {w1h_ff[1:0], w1l_ff};
      eff_width_ff[1] <= {w2h_ff[1:0], w2l_ff};
      eff_soft_ff[0] <= soft_ff[3:0];
      eff_soft_ff[1] <= dual ? soft_ff[3:0] : soft_ff[7:4];
    end
  end

  // plain field outputs straight from the register flops
  assign dual_phase_select = dual;
  assign error_amp_gain_select = mode_ff[`DCCR_B_GAIN +: 2];
  assign regulation_mode_select = mode_ff[`DCCR_B_CV +: 2];
  assign blanking_length_select = blank_ff[`DCCR_B_LEB +: 2];
  assign current_limit_filter_select = {blank_ff[`DCCR_B_FILT2], blank_ff[`DCCR_B_FILT1]};
  assign slope_ramp_code = {slope_ff[6:4], slope_ff[2:0]};
  assign spread_magnitude = spread_ff[`DCCR_B_SMAG +: 2];

  // ****************************************
  // spread-spectrum rate divider
  // ****************************************
  dccr_pkg::dccr_fmdiv_t fm_cnt_ff, fm_div;
  logic [3:0] fm_rate;
  logic fm_run;

  assign fm_rate = spread_ff[3:0];
  assign fm_run = (fm_rate < `DCCR_FM_OFF) && (spread_magnitude != 2'h0);
  // codes below eight step by 512, upper codes halve from 256
  assign fm_div = (fm_rate < `DCCR_FM_SPLIT) ?
    13'(`DCCR_FM_BASE - `DCCR_FM_STEP * fm_rate) :
    13'(`DCCR_FM_FINE >> (fm_rate - `DCCR_FM_SPLIT));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fm_cnt_ff <= '0;
      spread_tick <= 1'b0;
    end else if (!fm_run) begin
      fm_cnt_ff <= '0;
      spread_tick <= 1'b0;
    end else if (fm_cnt_ff >= 13'(fm_div - 13'h0001)) begin
      fm_cnt_ff <= '0;
      spread_tick <= 1'b1;
    end else begin
      fm_cnt_ff <= 13'(fm_cnt_ff + 13'h0001);
      spread_tick <= 1'b0;
    end
  end

  // ****************************************
  // dimming clock and width counter
  // ****************************************
  logic [2:0] dim_pre_ff;
  dccr_pkg::dccr_width_t dim_cnt_ff;

  // division is code plus one, code zero ticks every cycle
  assign dimming_clock_tick = (dim_pre_ff >= dimdiv_ff[2:0]);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dim_pre_ff <= 3'h0;
      dim_cnt_ff <= '0;
    end else if (dimming_clock_tick) begin
      dim_pre_ff <= 3'h0;
      dim_cnt_ff <= 10'(dim_cnt_ff + 10'h001);
    end else begin
      dim_pre_ff <= 3'(dim_pre_ff + 3'h1);
    end
  end

  // ****************************************
  // per channel clock, soft-start and dimming
  // ****************************************
  function automatic logic [6:0] dccr_ss_div(input logic [3:0] code);
    logic [111:0] tab;
    tab = `DCCR_SS_DIVS;
    return tab[code * `DCCR_SS_W +: `DCCR_SS_W];
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [3:0] sw_cnt_ff, sw_div;
      logic [6:0] ss_cnt_ff, ss_div;
      dccr_pkg::dccr_byte_t ramp_ff;
      dccr_pkg::dccr_width_t pos;
      logic on;
      logic dim_ff;

      // channel clock: 2, 4, 8 with the top code held at 8
      assign sw_div = (channel_clock_divider_ff[ch*2 +: 2] == `DCCR_SW_TOP) ? `DCCR_SW_MAX :
        4'(`DCCR_SW_MIN << channel_clock_divider_ff[ch*2 +: 2]);
      assign channel_clock_tick[ch] = (sw_cnt_ff >= 4'(sw_div - 4'h1));

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sw_cnt_ff <= 4'h0;
        end else if (channel_clock_tick[ch]) begin
          sw_cnt_ff <= 4'h0;
        end else begin
          sw_cnt_ff <= 4'(sw_cnt_ff + 4'h1);
        end
      end

      // channel is off at code eight or below
      assign on = (eff_iadj_ff[ch] > `DCCR_IADJ_OFF);
      assign channel_on[ch] = on;
      assign current_adjust_code[ch*8 +: 8] = eff_iadj_ff[ch];

      // soft-start ramp climbs once per divided clock and stops at the top
      assign ss_div = dccr_ss_div(eff_soft_ff[ch]);
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          ss_cnt_ff <= 7'h00;
          ramp_ff <= `DCCR_R_ZERO;
        end else if (!on) begin
          ss_cnt_ff <= 7'h00;
          ramp_ff <= `DCCR_R_ZERO;
        end else if (ss_div == 7'h00) begin
          ramp_ff <= `DCCR_RAMP_TOP;
        end else if (ss_cnt_ff >= 7'(ss_div - 7'h01)) begin
          ss_cnt_ff <= 7'h00;
          if (ramp_ff != `DCCR_RAMP_TOP) begin
            ramp_ff <= 8'(ramp_ff + 8'h01);
          end
        end else begin
          ss_cnt_ff <= 7'(ss_cnt_ff + 7'h01);
        end
      end
      assign soft_start_divider_ramp[ch*8 +: 8] = ramp_ff;

      // second channel runs half a period late unless in phase
      assign pos = (ch == 1 && !dimming_phase_select) ?
        10'(dim_cnt_ff + `DCCR_DIM_HALF) : dim_cnt_ff;
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          dim_ff <= 1'b0;
        end else if (internal_dimming_select) begin
          dim_ff <= (pos < eff_width_ff[ch]);
        end else begin
          dim_ff <= ext_dimming_in[ch];
        end
      end
      assign dimming_out[ch] = dim_ff;
    end
  endgenerate

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_lh_set: assert property (
    limp_home_pin |=> lh_bit_ff ##1 lh_bit_ff || $past(wr_mode))
    else $error("limp-home bit not set by pin");
  a_lh_keep: assert property (lh_bit_ff && !wr_mode |=> lh_bit_ff)
    else $error("limp-home bit dropped without a write");
  a_lh_idle: assert property (!lh_bit_ff && !limp_home_pin |=> !lh_bit_ff)
    else $error("limp-home bit set without the pin");
  a_lh_swap: assert property (
    limp_home_active |=> eff_iadj_ff[0] == $past(lhiadj1_ff))
    else $error("limp-home set not in use");
  a_dual_copy: assert property (
    dual && $stable(dual) |=> eff_iadj_ff[1] == eff_iadj_ff[0])
    else $error("channel two not following channel one");
  a_sw_fast: assert property (
    channel_clock_tick[0] && channel_clock_divider_ff[1:0] == 2'h0 && !reg_wr_stb ##1 !reg_wr_stb
    |-> !channel_clock_tick[0] ##1 channel_clock_tick[0])
    else $error("channel clock not divided by two");
  a_dim_div1: assert property (
    dimdiv_ff[2:0] == 3'h0 && $past(dimdiv_ff[2:0]) == 3'h0 |-> dimming_clock_tick)
    else $error("dimming clock not undivided");
  a_ext_dim: assert property (
    !internal_dimming_select |=> dimming_out == $past(ext_dimming_in))
    else $error("external dimming not passed");
  a_rsvd_zero: assert property (
    reg_addr == `DCCR_A_DIMDIV |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_ramp_top: assert property (
    channel_on[0] && soft_start_divider_ramp[7:0] == `DCCR_RAMP_TOP && $stable(eff_iadj_ff[0])
    |=> channel_on[0] == 1'b0 || soft_start_divider_ramp[7:0] == `DCCR_RAMP_TOP)
    else $error("soft-start ramp wrapped");
  a_fm_off: assert property (fm_rate >= `DCCR_FM_OFF |=> !spread_tick)
    else $error("modulation running while disabled");
endmodule // dccr_config_bank
`default_nettype wire

// >>> tb/dccr_host_model.sv
// host side model that writes and reads the config bank register port
`timescale 1ns/100ps
`default_nettype none
module dccr_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr_stb,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ****************************************
  // idle state and bus cycles
  // ****************************************
  initial begin
    reg_wr_stb = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // write: request set at a falling edge, taken at the next rising edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr_stb = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_stb = 1'b0;
    reg_wdata = ~d; // released data must not keep its last value
  endtask
  // read: read data is registered one rising edge after the address
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule // dccr_host_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking testbench of the dual channel config bank
`timescale 1ns/100ps
`include "dccr_map.svh"
`default_nettype none
module testbench;
  // ****************************************
  // signals, clock and instances
  // ****************************************
  logic clk_sys, sys_rst, stb, pin;
  logic [5:0] addr, sl;
  logic [7:0] wdata, rdata, rv;
  logic [1:0] ext, gn, rm, bl, fl, cct, smag, on, dout;
  logic dps, ids, dual, lha, stk, dtk;
  logic [15:0] iadj, ramp;
  int n_errors, checks_done;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  dccr_host_model dccr_host_model_inst (.clk_sys(clk_sys), .reg_wr_stb(stb), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata));
  dccr_config_bank dccr_config_bank_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_wr_stb(stb), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .limp_home_pin(pin), .ext_dimming_in(ext), .dimming_phase_select(dps),
    .internal_dimming_select(ids), .dual_phase_select(dual), .limp_home_active(lha),
    .error_amp_gain_select(gn), .regulation_mode_select(rm), .blanking_length_select(bl),
    .current_limit_filter_select(fl), .slope_ramp_code(sl), .channel_clock_tick(cct),
    .spread_magnitude(smag), .spread_tick(stk), .dimming_clock_tick(dtk),
    .current_adjust_code(iadj), .channel_on(on), .soft_start_divider_ramp(ramp), .dimming_out(dout));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    dccr_host_model_inst.wr(a, d);
    repeat (2) @(negedge clk_sys); // effective settings lag one cycle
  endtask
  function automatic logic tick(input int s);
    return s == 0 ? cct[0] : s == 1 ? cct[1] : s == 2 ? dtk : stk;
  endfunction
  // cycles between two ticks, 0 when none in the bound
  task automatic period(input int s, output int n);
    int i;
    n = 0;
    for (i = 0; i < 300 && !tick(s); i++) @(negedge clk_sys);
    if (!tick(s)) return;
    do begin
      @(negedge clk_sys);
      n++;
    end while (!tick(s) && n < 300);
    if (n >= 300) n = 0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [5:0] a;
    logic [7:0] r [14] = '{0, 0, 0, 0, 8'h55, 8'h05, 8'h77, 0, 0, 8'h01, 0, 0, 0, 0};
    logic [7:0] m [15] = '{0, 8'hEF, 8'hC9, 8'h0F, 8'h77, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07,
      8'hFF, 8'h03, 8'hFF, 8'h03, 0};
    for (int i = 0; i < 14; i++) begin
      a = 6'(i);
      dccr_host_model_inst.rd(a, rv);
      chk(16'(rv), 16'(r[i]));
    end
    for (int i = 1; i < 15; i++) begin
      a = 6'(i);
      dccr_host_model_inst.wr(a, 8'hFF);
      dccr_host_model_inst.rd(a, rv);
      chk(16'(rv), 16'(m[i]));
    end
    wr(`DCCR_A_MODE, 8'h00);
  endtask
  task automatic t_mode();
    wr(`DCCR_A_MODE, 8'h2D);
    chk(16'({dual, gn, rm}), 16'h1D);
    wr(`DCCR_A_BLANK, 8'h48);
    chk(16'({bl, fl}), 16'h06);
    wr(`DCCR_A_SLOPE, 8'h35);
    chk(16'(sl), 16'h1D);
    wr(`DCCR_A_MODE, 8'h00);
    ext = 2'h2;
    repeat (3) @(negedge clk_sys);
    chk(16'(dout), 16'h02);
  endtask
  task automatic t_dac();
    wr(`DCCR_A_IADJ1, 8'h08);
    chk(16'(on[0]), 16'h0);
    wr(`DCCR_A_SOFT, 8'h01);
    wr(`DCCR_A_IADJ1, 8'h09);
    rv = ramp[7:0];
    repeat (20) @(negedge clk_sys);
    chk(16'(ramp[7:0] - rv), 16'h0A);
    wr(`DCCR_A_IADJ1, 8'h09);
    chk(16'({on[0], iadj[7:0]}), 16'h109);
    wr(`DCCR_A_IADJ2, 8'h40);
    chk(iadj, 16'h4009);
    wr(`DCCR_A_MODE, 8'h20);
    chk(iadj, 16'h0909);
    wr(`DCCR_A_SOFT, 8'h00);
    chk(ramp, 16'hFFFF);
    wr(`DCCR_A_MODE, 8'h00);
  endtask
  task automatic t_limp();
    wr(`DCCR_A_LHIADJ1, 8'h30);
    pin = 1'b1;
    repeat (2) @(negedge clk_sys);
    wr(`DCCR_A_MODE, 8'h00);
    dccr_host_model_inst.rd(`DCCR_A_MODE, rv);
    chk(16'({lha, rv[4]}), 16'h3);
    pin = 1'b0;
    repeat (3) @(negedge clk_sys);
    dccr_host_model_inst.rd(`DCCR_A_MODE, rv);
    chk(16'({lha, rv[4], iadj[7:0]}), 16'h330);
    wr(`DCCR_A_MODE, 8'h00);
    dccr_host_model_inst.rd(`DCCR_A_MODE, rv);
    chk(16'({lha, rv[4], iadj[7:0]}), 16'h009);
    wr(`DCCR_A_MODE, 8'h10);
    dccr_host_model_inst.rd(`DCCR_A_MODE, rv);
    chk(16'({lha, rv[4]}), 16'h0);
    pin = 1'b1;
    @(negedge clk_sys);
    pin = 1'b0;
    wr(`DCCR_A_MODE, 8'h10);
    dccr_host_model_inst.rd(`DCCR_A_MODE, rv);
    chk(16'({lha, rv[4]}), 16'h3);
    wr(`DCCR_A_MODE, 8'h00);
  endtask
  task automatic t_clocks();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(`DCCR_A_CHANNEL_CLOCK_DIVIDER, 8'(c * 5));
      period(1, n);
      chk(16'(n), c == 0 ? 16'h2 : c == 1 ? 16'h4 : 16'h8);
    end
    for (int c = 0; c < 8; c++) begin
      wr(`DCCR_A_DIMDIV, 8'(c));
      period(2, n);
      chk(16'(n), 16'(c + 1));
    end
    wr(`DCCR_A_SPREAD, 8'h1D);
    period(3, n);
    chk(16'({smag, n[7:0]}), 16'h108);
    wr(`DCCR_A_SPREAD, 8'h1C);
    period(3, n);
    chk(16'(n), 16'h10);
    wr(`DCCR_A_SPREAD, 8'h1E);
    period(3, n);
    chk(16'(n), 16'h0);
    wr(`DCCR_A_SPREAD, 8'h0D);
    period(3, n);
    chk(16'(n), 16'h0);
  endtask
  // internal dimming over one full width-counter cycle, both phase settings
  task automatic t_dim();
    int h, s;
    wr(`DCCR_A_DIMDIV, 8'h00);
    wr(`DCCR_A_W1L, 8'h34);
    wr(`DCCR_A_W1H, 8'h01);
    wr(`DCCR_A_W2L, 8'h34);
    wr(`DCCR_A_W2H, 8'h01);
    for (int p = 0; p < 2; p++) begin
      wr(`DCCR_A_MODE, p == 0 ? 8'h40 : 8'hC0);
      chk(16'({dps, ids}), p == 0 ? 16'h1 : 16'h3);
      h = 0;
      s = 0;
      repeat (1024) begin
        @(negedge clk_sys);
        h += dout[0];
        s += (dout[0] == dout[1]);
      end
      chk(16'(h), 16'h134);
      chk(16'(s), p == 0 ? 16'h198 : 16'h400);
    end
    wr(`DCCR_A_MODE, 8'h00);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    n_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    pin = 1'b0;
    ext = 2'h0;
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_regs();
    t_mode();
    t_dac();
    t_limp();
    t_clocks();
    t_dim();
    finish_test();
  end
  // run limit counts as a mismatch
  initial begin
    #5ms;
    n_errors++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
